/* File: core/gopd_pkg.sv */
// Constants, register map and carrier types of the gauge option decoder
// Assumes a single 10 MHz system clock
package gopd_pkg;
  localparam int CLK_HZ         = 10_000_000;
  localparam int SLEEP_TIME_MS  = 2000;
  localparam int FLAG_DELAY_MS  = 1000;
  localparam int SLEEP_CYC      = SLEEP_TIME_MS * (CLK_HZ / 1000);
  localparam int FLAG_DELAY_CYC = FLAG_DELAY_MS * (CLK_HZ / 1000);
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_GAUGE = 10'h029;
  localparam logic [9:0] IDX_MHIGH = 10'h02a;
  localparam logic [9:0] IDX_MLOW  = 10'h02b;
  localparam logic [9:0] IDX_MISC2 = 10'h139;
  localparam logic [9:0] IDX_PFCFG = 10'h11f;
  localparam logic [9:0] IDX_PCT   = 10'h300;
  localparam logic [9:0] IDX_CTRL  = 10'h301;
  localparam logic [9:0] IDX_STAT  = 10'h302;
  // Gauge option byte fields
  localparam int GB_FIXED = 7;
  localparam int GB_SYNC  = 6;
  localparam int GB_LEARN = 5;
  localparam int GB_COMP  = 4;
  localparam int GB_SRC   = 3;
  localparam int GB_OVB   = 2;
  localparam int GB_CONT  = 1;
  localparam int GB_ONCE  = 0;
  // Misc option high byte fields (b15..b8 held as 7..0), then the low byte field
  localparam int MH_SENS  = 7;
  localparam int MH_ZERO  = 6;
  localparam int MH_FEC   = 5;
  localparam int MH_SLP   = 4;
  localparam int MH_OT    = 3;
  localparam int MH_CLED  = 2;
  localparam int MH_ONE   = 1;
  localparam int MH_VOD   = 0;
  localparam int ML_ALED  = 7;
  // Misc option 2 fields, then the failure config and control register fields
  localparam int M2_REMAP = 0;
  localparam int M2_ICLMP = 1;
  localparam int M2_CHARGE_LEVEL_CAP  = 2;
  localparam int M2_VCLMP = 3;
  localparam int M2_DEPF  = 4;
  localparam int PF_FE    = 3;
  localparam int CTRL_RELOAD = 0;
  // Reset values, then the cell command bases and the charge level cap
  localparam logic [7:0] RST_GAUGE = 8'h00;
  localparam logic [7:0] RST_MHIGH = 8'h02;
  localparam logic [7:0] RST_MLOW  = 8'h00;
  localparam logic [7:0] RST_MISC2 = 8'h00;
  localparam logic [7:0] RST_PFCFG = 8'h00;
  localparam logic [7:0] RST_PCT   = 8'h64;
  localparam logic [7:0] CMD_CELL_STD = 8'h3c;
  localparam logic [7:0] CMD_CELL_ALT = 8'h38;
  localparam logic [7:0] SOC_CAP      = 8'h63;

  typedef struct packed {
    logic             term;
    logic [15:0]      pack_v;
    logic [15:0]      min_cell;
    logic [15:0]      max_cell;
    logic [15:0]      safety_v;
    logic [15:0]      precharge_v;
    logic [15:0]      full_cap;
    logic [2:0][15:0] th_stored;
    logic [2:0][15:0] th_comp;
    logic [2:0]       cells;
    logic             overheat;
    logic             smb_clk;
    logic             smb_dat;
    logic             discharging_flag;
    logic             fc;
    logic             depleted;
    logic             cell_ov_raw;
    logic             cell_uv_raw;
    logic             cap_alarm;
    logic             cmd_valid;
    logic [7:0]       cmd;
    logic [15:0]      chg_cur_req;
    logic [15:0]      chg_volt_req;
    logic [7:0]       relative_charge_level_raw;
    logic [7:0]       absolute_charge_level_raw;
  } gopd_in_t;

  typedef struct packed {
    logic             rm_load;
    logic [15:0]      rm_value;
    logic             learn_indep;
    logic [2:0][15:0] th_out;
    logic [15:0]      eod_volt;
    logic             ov_fault;
    logic             mid_cont;
    logic             mid_once;
    logic             sensor_int;
    logic             fe_check;
    logic             fe_pf_detect;
    logic             sleep;
    logic             fet_ot_off;
    logic             led_en;
    logic             led_blink;
    logic             led_off;
    logic             cell_over;
    logic             cell_under;
    logic             cell_hit;
    logic [1:0]       cell_idx;
    logic [15:0]      chg_current;
    logic [15:0]      chg_voltage;
    logic [7:0]       relative_charge_level;
    logic [7:0]       absolute_charge_level;
    logic             chg_fet_on;
  } gopd_out_t;

  typedef struct packed {
    logic [5:0][7:0] stage;
    logic [5:0][7:0] act;
    logic            load_pend;
    logic            once_done;
    logic            term_seen;
    logic [31:0]     slp_cnt;
    logic [31:0]     ov_cnt;
    logic [31:0]     uv_cnt;
    logic            dph;
    logic            dwr;
    logic [9:0]      didx;
    logic [31:0]     hrdata;
    logic            hready;
    gopd_out_t       out;
  } gopd_state_t;
endpackage

/* File: core/gopd_top.sv */
// Option decoder: AHB-Lite option registers decoded into gauge controls
// Assumes all gauge inputs are synchronous to CLOCK_I
`timescale 1ns/1ps
module gopd_top #(
  parameter int unsigned SLEEP_CYCLES = gopd_pkg::SLEEP_CYC,
  parameter int unsigned DELAY_CYCLES = gopd_pkg::FLAG_DELAY_CYC
) (
  // Clock, reset, enable
  input  wire logic              CLOCK_I,
  input  wire logic              ARST_N_I,
  input  wire logic              CE_I,
  // AHB-Lite slave
  input  wire logic              HSEL_I,
  input  wire logic [31:0]       HADDR_I,
  input  wire logic [1:0]        HTRANS_I,
  input  wire logic              HWRITE_I,
  input  wire logic [2:0]        HSIZE_I,
  input  wire logic [31:0]       HWDATA_I,
  input  wire logic              HREADY_I,
  output logic                   HREADYOUT_O,
  output logic                   HRESP_O,
  output logic [31:0]            HRDATA_O,
  // Gauge side
  input  wire gopd_pkg::gopd_in_t GAUGE_I,
  output gopd_pkg::gopd_out_t    GAUGE_O
);
  if (SLEEP_CYCLES < 1 || SLEEP_CYCLES > 32'h7fffffff) begin : g_chk_sleep
    $error("SLEEP_CYCLES out of range");
  end
  if (DELAY_CYCLES < 1 || DELAY_CYCLES > 32'h7fffffff) begin : g_chk_delay
    $error("DELAY_CYCLES out of range");
  end

  localparam int S_GAUGE = 0;
  localparam int S_MHIGH = 1;
  localparam int S_MLOW  = 2;
  localparam int S_MISC2 = 3;
  localparam int S_PFCFG = 4;
  localparam int S_PCT   = 5;
  localparam logic [5:0][7:0] RST_SET = {gopd_pkg::RST_PCT, gopd_pkg::RST_PFCFG,
    gopd_pkg::RST_MISC2, gopd_pkg::RST_MLOW, gopd_pkg::RST_MHIGH, gopd_pkg::RST_GAUGE};

  gopd_pkg::gopd_state_t s_reg;
  gopd_pkg::gopd_state_t s_next;

  // Saturating counter of cycles a condition has held
  function automatic logic [31:0] step_cnt(input logic [31:0] cnt, input logic on,
                                           input logic [31:0] lim);
    if (!on) return 32'h0;
    if (cnt >= lim) return lim;
    return cnt + 32'h1;
  endfunction

  function automatic logic [7:0] cap_soc(input logic [7:0] v, input logic on);
    return (on && v > gopd_pkg::SOC_CAP) ? gopd_pkg::SOC_CAP : v;
  endfunction

  function automatic logic [15:0] pct_of(input logic [15:0] full, input logic [7:0] pct);
    logic [23:0] p;
    p = full * pct;
    return 16'(p / 24'd100);
  endfunction

  // Read value of a register from the given staging set
  function automatic logic [31:0] rd(input logic [9:0] idx, input gopd_pkg::gopd_state_t st);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      gopd_pkg::IDX_GAUGE: v = st.stage[S_GAUGE];
      gopd_pkg::IDX_MHIGH: begin
        v = st.stage[S_MHIGH];
        v[gopd_pkg::MH_ZERO] = 1'b0;
        v[gopd_pkg::MH_ONE] = 1'b1;
      end
      gopd_pkg::IDX_MLOW:  v = st.stage[S_MLOW];
      gopd_pkg::IDX_MISC2: v = st.stage[S_MISC2];
      gopd_pkg::IDX_PFCFG: v = st.stage[S_PFCFG];
      gopd_pkg::IDX_PCT:   v = st.stage[S_PCT];
      gopd_pkg::IDX_STAT:  v = {4'h0, st.out.sleep, st.term_seen, st.once_done, st.load_pend};
      default:             v = 8'h00;
    endcase
    return {24'h0, v};
  endfunction

  logic [7:0]  g;
  logic [7:0]  mh;
  logic [7:0]  ml;
  logic [7:0]  m2;
  logic        both_low;
  logic [18:0] ov_prod;
  logic [7:0]  cbase;

  always_comb begin
    s_next = s_reg;
    g  = s_reg.act[S_GAUGE];
    mh = s_reg.act[S_MHIGH];
    ml = s_reg.act[S_MLOW];
    m2 = s_reg.act[S_MISC2];
    both_low = !GAUGE_I.smb_clk && !GAUGE_I.smb_dat;
    ov_prod = GAUGE_I.max_cell * GAUGE_I.cells;
    cbase = m2[gopd_pkg::M2_REMAP] ? gopd_pkg::CMD_CELL_ALT : gopd_pkg::CMD_CELL_STD;
    // Data phase write, then address phase of the next transfer
    if (s_reg.dph && s_reg.dwr) begin
      case (s_reg.didx)
        gopd_pkg::IDX_GAUGE: s_next.stage[S_GAUGE] = HWDATA_I[7:0];
        gopd_pkg::IDX_MHIGH: s_next.stage[S_MHIGH] = HWDATA_I[7:0];
        gopd_pkg::IDX_MLOW:  s_next.stage[S_MLOW] = HWDATA_I[7:0];
        gopd_pkg::IDX_MISC2: s_next.stage[S_MISC2] = HWDATA_I[7:0];
        gopd_pkg::IDX_PFCFG: s_next.stage[S_PFCFG] = HWDATA_I[7:0];
        gopd_pkg::IDX_PCT:   s_next.stage[S_PCT] = HWDATA_I[7:0];
        gopd_pkg::IDX_CTRL:  s_next.load_pend = HWDATA_I[gopd_pkg::CTRL_RELOAD];
        default: ;
      endcase
    end
    s_next.dph = HSEL_I && HREADY_I && HTRANS_I[1];
    s_next.dwr = HWRITE_I;
    s_next.didx = HADDR_I[11:2];
    if (s_next.dph && !HWRITE_I) begin
      s_next.hrdata = rd(HADDR_I[11:2], s_next);
    end
    s_next.hready = 1'b1;
    // Staged options take effect only on a load
    if (s_reg.load_pend) begin
      s_next.act = s_reg.stage;
      // A reload request in this same cycle wins over the clear
      s_next.load_pend = s_reg.dph && s_reg.dwr && s_reg.didx == gopd_pkg::IDX_CTRL
                         && HWDATA_I[gopd_pkg::CTRL_RELOAD];
    end
    s_next.out.rm_load = GAUGE_I.term && g[gopd_pkg::GB_SYNC];
    s_next.out.rm_value = pct_of(GAUGE_I.full_cap, s_reg.act[S_PCT]);
    s_next.out.learn_indep = g[gopd_pkg::GB_LEARN];
    for (int k = 0; k < 3; k++) begin
      s_next.out.th_out[k] = g[gopd_pkg::GB_COMP] ? GAUGE_I.th_comp[k]
                                                   : GAUGE_I.th_stored[k];
      if (g[gopd_pkg::GB_FIXED] && k > 0 && s_next.out.th_out[k] < GAUGE_I.th_stored[0]) begin
        s_next.out.th_out[k] = GAUGE_I.th_stored[0];
      end
    end
    if (g[gopd_pkg::GB_FIXED]) begin
      s_next.out.th_out[0] = GAUGE_I.th_stored[0];
    end
    s_next.out.eod_volt = g[gopd_pkg::GB_SRC] ? GAUGE_I.pack_v : GAUGE_I.min_cell;
    s_next.out.ov_fault = g[gopd_pkg::GB_OVB] ? (ov_prod > {3'h0, GAUGE_I.safety_v})
                                               : (GAUGE_I.pack_v > GAUGE_I.safety_v);
    s_next.out.mid_cont = g[gopd_pkg::GB_CONT];
    s_next.out.mid_once = 1'b0;
    if (!s_reg.load_pend && !s_reg.once_done && g[gopd_pkg::GB_ONCE]) begin
      s_next.out.mid_once = 1'b1;
      s_next.once_done = 1'b1;
    end
    s_next.out.sensor_int = mh[gopd_pkg::MH_SENS];
    s_next.out.fe_check = mh[gopd_pkg::MH_FEC];
    s_next.out.fe_pf_detect = mh[gopd_pkg::MH_FEC] && s_reg.act[S_PFCFG][gopd_pkg::PF_FE];
    s_next.slp_cnt = step_cnt(s_reg.slp_cnt, both_low, 32'(SLEEP_CYCLES));
    s_next.out.sleep = !mh[gopd_pkg::MH_SLP] && both_low
                       && s_next.slp_cnt >= 32'(SLEEP_CYCLES);
    s_next.out.fet_ot_off = GAUGE_I.overheat && mh[gopd_pkg::MH_OT];
    s_next.out.led_en = GAUGE_I.discharging_flag || mh[gopd_pkg::MH_CLED];
    s_next.out.led_blink = GAUGE_I.cap_alarm && !ml[gopd_pkg::ML_ALED];
    s_next.out.led_off = GAUGE_I.cap_alarm && ml[gopd_pkg::ML_ALED];
    s_next.ov_cnt = step_cnt(s_reg.ov_cnt, GAUGE_I.cell_ov_raw, 32'(DELAY_CYCLES));
    s_next.uv_cnt = step_cnt(s_reg.uv_cnt, GAUGE_I.cell_uv_raw, 32'(DELAY_CYCLES));
    s_next.out.cell_over = GAUGE_I.cell_ov_raw && (!mh[gopd_pkg::MH_VOD]
                           || s_next.ov_cnt >= 32'(DELAY_CYCLES));
    s_next.out.cell_under = GAUGE_I.cell_uv_raw && (!mh[gopd_pkg::MH_VOD]
                            || s_next.uv_cnt >= 32'(DELAY_CYCLES));
    s_next.out.cell_hit = GAUGE_I.cmd_valid && GAUGE_I.cmd[7:2] == cbase[7:2];
    s_next.out.cell_idx = GAUGE_I.cmd[1:0];
    s_next.out.chg_current = (m2[gopd_pkg::M2_ICLMP] && GAUGE_I.discharging_flag) ? 16'h0000
                             : GAUGE_I.chg_cur_req;
    s_next.out.chg_voltage = (m2[gopd_pkg::M2_VCLMP] && GAUGE_I.fc) ? 16'h0000
                             : GAUGE_I.chg_volt_req;
    s_next.term_seen = s_reg.term_seen || GAUGE_I.term;
    s_next.out.relative_charge_level = cap_soc(GAUGE_I.relative_charge_level_raw, m2[gopd_pkg::M2_CHARGE_LEVEL_CAP] && !s_reg.term_seen);
    s_next.out.absolute_charge_level = cap_soc(GAUGE_I.absolute_charge_level_raw, m2[gopd_pkg::M2_CHARGE_LEVEL_CAP] && !s_reg.term_seen);
    s_next.out.chg_fet_on = m2[gopd_pkg::M2_DEPF] && GAUGE_I.depleted
                            && GAUGE_I.min_cell > GAUGE_I.precharge_v;
  end

  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      s_reg <= '0;
      s_reg.stage <= RST_SET;
      s_reg.act <= RST_SET;
      s_reg.load_pend <= 1'b1;
      s_reg.hready <= 1'b1;
    end else if (CE_I) begin
      s_reg <= s_next;
    end
  end

  assign HREADYOUT_O = s_reg.hready;
  assign HRESP_O = 1'b0;
  assign HRDATA_O = s_reg.hrdata;
  assign GAUGE_O = s_reg.out;

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!ARST_N_I);

  property p_sync;
    CE_I && GAUGE_I.term && s_reg.act[S_GAUGE][gopd_pkg::GB_SYNC] |=> GAUGE_O.rm_load;
  endproperty
  a_sync: assert property (p_sync) else $error("capacity load missed");

  property p_nosync;
    CE_I && !s_reg.act[S_GAUGE][gopd_pkg::GB_SYNC] |=> !GAUGE_O.rm_load;
  endproperty
  a_nosync: assert property (p_nosync) else $error("capacity load while off");

  property p_eod;
    CE_I |=> GAUGE_O.eod_volt == ($past(s_reg.act[S_GAUGE][gopd_pkg::GB_SRC])
             ? $past(GAUGE_I.pack_v) : $past(GAUGE_I.min_cell));
  endproperty
  a_eod: assert property (p_eod) else $error("wrong discharge source");

  property p_once;
    GAUGE_O.mid_once |=> !GAUGE_O.mid_once [*8];
  endproperty
  a_once: assert property (p_once) else $error("second one-time correction");

  property p_pf;
    GAUGE_O.fe_pf_detect |-> GAUGE_O.fe_check;
  endproperty
  a_pf: assert property (p_pf) else $error("failure detect without check");

  property p_sleep;
    GAUGE_O.sleep |-> $past(s_reg.slp_cnt) >= 32'(SLEEP_CYCLES) - 32'h1
                      && !s_reg.act[S_MHIGH][gopd_pkg::MH_SLP] || $past(s_reg.load_pend);
  endproperty
  a_sleep: assert property (p_sleep) else $error("early sleep");

  property p_led;
    CE_I && !GAUGE_I.discharging_flag && !s_reg.act[S_MHIGH][gopd_pkg::MH_CLED] && !s_reg.load_pend
      |=> !GAUGE_O.led_en;
  endproperty
  a_led: assert property (p_led) else $error("LEDs on while charging");

  property p_cur;
    CE_I && GAUGE_I.discharging_flag && s_reg.act[S_MISC2][gopd_pkg::M2_ICLMP] |=> GAUGE_O.chg_current == 16'h0;
  endproperty
  a_cur: assert property (p_cur) else $error("current not clamped");

  property p_soc;
    CE_I && s_reg.act[S_MISC2][gopd_pkg::M2_CHARGE_LEVEL_CAP] && !s_reg.term_seen
      |=> GAUGE_O.relative_charge_level <= gopd_pkg::SOC_CAP && GAUGE_O.absolute_charge_level <= gopd_pkg::SOC_CAP;
  endproperty
  a_soc: assert property (p_soc) else $error("charge level above cap");

  property p_volt;
    CE_I && GAUGE_I.fc && s_reg.act[S_MISC2][gopd_pkg::M2_VCLMP] |=> GAUGE_O.chg_voltage == 16'h0;
  endproperty
  a_volt: assert property (p_volt) else $error("voltage not clamped");

  property p_ready;
    HREADYOUT_O && !HRESP_O;
  endproperty
  a_ready: assert property (p_ready) else $error("bus stalled or error");

  c_load: cover property (CE_I && GAUGE_I.term ##1 GAUGE_O.rm_load);
  c_sleep: cover property ($rose(GAUGE_O.sleep));
  c_cell: cover property (GAUGE_O.cell_hit);
  c_once: cover property (GAUGE_O.mid_once);
endmodule

/* File: tb/gopd_gauge_model.sv */
// Gauge-side model: firmware and host levels seen by the option decoder
// Assumes the bench sets wanted levels just after a rising edge
`timescale 1ns/1ps
module gopd_gauge_model (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               arst_n_i,
  // Bench requests
  input  wire gopd_pkg::gopd_in_t want_i,
  input  wire logic               term_req_i,
  input  wire logic               bus_low_i,
  // Levels towards the decoder
  output gopd_pkg::gopd_in_t      gauge_o
);
  logic               req_q;
  gopd_pkg::gopd_in_t idle;
  gopd_pkg::gopd_in_t lvl;
  // Bus lines idle high through their pull-ups
  always_comb begin
    idle         = '0;
    idle.smb_clk = 1'b1;
    idle.smb_dat = 1'b1;
    lvl          = want_i;
    lvl.smb_clk  = !bus_low_i;
    lvl.smb_dat  = !bus_low_i;
    // One termination pulse per request
    lvl.term     = term_req_i && !req_q;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gauge_o <= idle;
      req_q   <= 1'b0;
    end else begin
      gauge_o <= lvl;
      req_q   <= term_req_i;
    end
  end
endmodule

/* File: tb/tb.sv */
// Self-checking bench of the option decoder with a gauge-side model
// Assumes short sleep and delay counts set through the parameters
`timescale 1ns/1ps
module tb;
  logic                clk = 1'b0;
  logic                arst_n = 1'b0;
  logic                hsel = 1'b0;
  logic [31:0]         haddr = '0;
  logic [1:0]          htrans = '0;
  logic                hwrite = 1'b0;
  logic [31:0]         hwdata = '0;
  logic                hreadyout;
  logic                hresp;
  logic [31:0]         hrdata;
  gopd_pkg::gopd_in_t  want = '0;
  gopd_pkg::gopd_in_t  nx = '0;
  gopd_pkg::gopd_in_t  gin;
  gopd_pkg::gopd_out_t gout;
  logic                term_req = 1'b0;
  logic                bus_low = 1'b0;
  logic                ce = 1'b1;
  logic                any_once = 1'b0;
  int                  once_n = 0;
  int                  bad_count = 0;
  int                  total_checks = 0;
  int                  cyc = 0;
  int                  n;
  logic [31:0]         r;
  logic [7:0]          g = '0;
  logic [7:0]          old;
  logic [7:0]          mh;
  logic [7:0]          ml;
  logic [7:0]          m2;
  logic [7:0]          pf;
  logic [9:0]          idx [7];
  logic [7:0]          rv [7];

  always #50 clk = ~clk;

  gopd_top #(.SLEEP_CYCLES(20), .DELAY_CYCLES(10)) dut (
    .CLOCK_I(clk), .ARST_N_I(arst_n), .CE_I(ce), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hreadyout), .HREADYOUT_O(hreadyout), .HRESP_O(hresp), .HRDATA_O(hrdata),
    .GAUGE_I(gin), .GAUGE_O(gout));

  gopd_gauge_model model (.clk_i(clk), .arst_n_i(arst_n), .want_i(want),
    .term_req_i(term_req), .bus_low_i(bus_low), .gauge_o(gin));

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      $display("Error %0t %s got %h want %h", $time, m, got, exp);
      bad_count++;
    end
  endtask

  // Single word transfer; read data taken at the end of the data phase
  task automatic bus(input logic w, input logic [9:0] i, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, i, 2'h0};
    do @(posedge clk); while (hreadyout !== 1'b1 && cyc < 5000);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hreadyout !== 1'b1 && cyc < 5000);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0, "okay response");
  endtask

  task automatic load(input logic [9:0] i, input logic [7:0] d);
    bus(1'b1, i, d);
    bus(1'b1, gopd_pkg::IDX_CTRL, 8'h01);
    repeat (5) @(posedge clk);
  endtask

  function automatic logic [15:0] exp_th(input int k, input logic [7:0] o,
                                         input gopd_pkg::gopd_in_t x);
    logic [15:0] v;
    v = o[4] ? x.th_comp[k] : x.th_stored[k];
    if (o[7] && (k == 0 || v < x.th_stored[0])) v = x.th_stored[0];
    return v;
  endfunction

  function automatic logic exp_ov(input logic [7:0] o, input gopd_pkg::gopd_in_t x);
    if (o[2]) return ({3'h0, x.max_cell} * x.cells) > {3'h0, x.safety_v};
    return x.pack_v > x.safety_v;
  endfunction

  // Counts one-time correction pulses
  always @(posedge clk) begin
    if (gout.mid_once === 1'b1) once_n <= once_n + 1;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    n = $urandom(93);
    idx = '{gopd_pkg::IDX_GAUGE, gopd_pkg::IDX_MHIGH, gopd_pkg::IDX_MLOW, gopd_pkg::IDX_MISC2,
            gopd_pkg::IDX_PFCFG, gopd_pkg::IDX_PCT, 10'h200};
    rv = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h64, 8'h00};
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    bus(1'b1, 10'h200, 8'hff);
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, idx[i], 8'h00);
      chk(r, {24'h0, rv[i]}, "reset value");
    end
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      old = g;
      g = 8'($urandom);
      any_once = any_once | g[0];
      mh = 8'($urandom) & 8'hfe;
      ml = 8'($urandom);
      m2 = 8'($urandom);
      pf = 8'($urandom);
      for (int b = 0; b < $bits(nx); b++) nx[b] = 1'($urandom);
      nx.cmd = 8'h38 + 8'($urandom_range(0, 7));
      nx.cmd_valid = 1'b1;
      bus(1'b1, gopd_pkg::IDX_GAUGE, g);
      bus(1'b1, gopd_pkg::IDX_MHIGH, mh);
      bus(1'b1, gopd_pkg::IDX_MLOW, ml);
      bus(1'b1, gopd_pkg::IDX_MISC2, m2);
      bus(1'b1, gopd_pkg::IDX_PFCFG, pf);
      bus(1'b0, gopd_pkg::IDX_GAUGE, 8'h00);
      chk(r, {24'h0, g}, "gauge readback");
      chk(gout.learn_indep, old[5], "held before reload");
      want <= nx;
      load(gopd_pkg::IDX_CTRL, 8'h01);
      chk(gout.learn_indep, g[5], "learn style");
      for (int k = 0; k < 3; k++) chk(gout.th_out[k], exp_th(k, g, nx), "threshold");
      chk(gout.eod_volt, g[3] ? nx.pack_v : nx.min_cell, "eod source");
      chk(gout.ov_fault, exp_ov(g, nx), "overvoltage");
      chk(gout.mid_cont, g[1], "mid correction");
      chk(gout.sensor_int, mh[7], "sensor");
      chk({gout.fe_check, gout.fe_pf_detect}, {mh[5], mh[5] & pf[3]}, "front end");
      chk(gout.fet_ot_off, mh[3] & nx.overheat, "overheat fet");
      chk(gout.led_en, nx.discharging_flag | mh[2], "charge led");
      chk(gout.cell_over, nx.cell_ov_raw, "cell flag");
      chk(gout.cell_under, nx.cell_uv_raw, "cell under flag");
      chk({gout.led_blink, gout.led_off}, {nx.cap_alarm & !ml[7], nx.cap_alarm & ml[7]},
          "alarm led");
      chk({gout.cell_hit, gout.cell_idx},
          {nx.cmd[7:2] == (m2[0] ? 6'h0e : 6'h0f), nx.cmd[1:0]}, "cell command");
      chk(gout.chg_current, (m2[1] & nx.discharging_flag) ? 16'h0 : nx.chg_cur_req, "current");
      chk(gout.relative_charge_level, (m2[2] && nx.relative_charge_level_raw > 8'h63) ? 8'h63 : nx.relative_charge_level_raw, "soc");
      chk(gout.absolute_charge_level, (m2[2] && nx.absolute_charge_level_raw > 8'h63) ? 8'h63 : nx.absolute_charge_level_raw, "absolute_charge_level");
      chk(gout.chg_voltage, (m2[3] & nx.fc) ? 16'h0 : nx.chg_volt_req, "voltage");
      chk(gout.chg_fet_on, m2[4] & nx.depleted & (nx.min_cell > nx.precharge_v),
          "depleted fet");
    end
    chk(once_n, {31'h0, any_once}, "one-time correction");
    $display("test random options done");
    load(gopd_pkg::IDX_MHIGH, 8'h00);
    bus_low <= 1'b1;
    repeat (12) @(posedge clk);
    chk(gout.sleep, 1'b0, "early sleep");
    repeat (20) @(posedge clk);
    chk(gout.sleep, 1'b1, "sleep");
    bus_low <= 1'b0;
    load(gopd_pkg::IDX_MHIGH, 8'h10);
    bus_low <= 1'b1;
    repeat (40) @(posedge clk);
    chk(gout.sleep, 1'b0, "sleep inhibited");
    bus_low <= 1'b0;
    $display("test sleep done");
    nx.cell_ov_raw = 1'b0;
    nx.cell_uv_raw = 1'b0;
    want <= nx;
    load(gopd_pkg::IDX_MHIGH, 8'h01);
    nx.cell_ov_raw = 1'b1;
    nx.cell_uv_raw = 1'b1;
    want <= nx;
    repeat (6) @(posedge clk);
    chk(gout.cell_over, 1'b0, "flag delayed");
    chk(gout.cell_under, 1'b0, "under flag delayed");
    repeat (16) @(posedge clk);
    chk(gout.cell_over, 1'b1, "flag after delay");
    chk(gout.cell_under, 1'b1, "under flag after delay");
    $display("test flag delay done");
    nx.relative_charge_level_raw = 8'h64;
    nx.full_cap = 16'($urandom);
    want <= nx;
    bus(1'b1, gopd_pkg::IDX_PCT, 8'h32);
    bus(1'b1, gopd_pkg::IDX_MISC2, 8'h04);
    load(gopd_pkg::IDX_GAUGE, 8'h40);
    chk(gout.relative_charge_level, 8'h63, "soc capped");
    for (int s = 0; s < 2; s++) begin
      term_req <= 1'b1;
      n = 0;
      repeat (8) begin
        @(posedge clk);
        term_req <= 1'b0;
        if (gout.rm_load === 1'b1) begin
          n++;
          chk(gout.rm_value, 16'(({16'h0, nx.full_cap} * 32'h32) / 32'h64), "rm");
        end
      end
      chk(n, (s == 0) ? 1 : 0, "rm load count");
      chk(gout.relative_charge_level, 8'h64, "soc released");
      load(gopd_pkg::IDX_GAUGE, 8'h00);
    end
    $display("test termination done");
    ce <= 1'b0;
    r = {16'h0, nx.min_cell};
    nx.min_cell = ~nx.min_cell;
    want <= nx;
    repeat (4) @(posedge clk);
    chk(gout.eod_volt, r, "frozen while disabled");
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    chk(gout.eod_volt, nx.min_cell, "runs when enabled");
    $display("test clock enable done");
    n = once_n;
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, gout !== '0}, 32'h0, "outputs in reset");
    chk({31'h0, hreadyout}, 32'h1, "ready in reset");
    chk(hrdata, 32'h0, "read data in reset");
    arst_n <= 1'b1;
    load(gopd_pkg::IDX_GAUGE, 8'h01);
    repeat (3) @(posedge clk);
    chk(once_n - n, 1, "one-time after reset");
    bus(1'b0, gopd_pkg::IDX_PCT, 8'h00);
    chk(r, 32'h64, "percentage after reset");
    $display("test second reset done");
    results();
  end
endmodule
